// ---- rtl/ifs_pkg.sv ----
// Constants, register map and types for the flash programming sequencer
package ifs_pkg;

  localparam int CLK_FREQ_MHZ = 250;

  // Least time in ns to whole clock cycles, rounded up, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * CLK_FREQ_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WORD_W      = 16;
  localparam int BYTE_W      = 8;
  localparam int FADDR_W     = 16;
  localparam int PAGE_WORDS  = 128;
  localparam int IDX_W       = 7;
  localparam int PAGE_W      = FADDR_W - IDX_W;
  localparam int TIMER_W     = 16;
  localparam int REG_ADDR_W  = 8;
  localparam int NUM_DATA    = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_RCTRL     = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO   = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI   = 8'h0C;
  localparam logic [7:0] OFS_DATA_BASE = 8'h10;
  localparam logic [7:0] OFS_DATA_LAST = 8'h2C;
  localparam logic [7:0] OFS_DATA_HI0  = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h30;

  // Programming control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WT_BIT   = 3;
  localparam int CTRL_UT_BIT   = 4;
  localparam int CTRL_CLEAR_WRITE_BUFFER_BIT_BIT = 5;
  localparam int CTRL_EN_BIT   = 6;
  localparam int CTRL_RDEN_BIT = 7;

  // Read control register fields
  localparam int RCTRL_RT_BIT   = 0;
  localparam int RCTRL_TSEL_BIT = 1;

  // Status register fields
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_WINDOW_BIT = 1;

  // Command modes
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_READ   = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  localparam logic [7:0]         BYTE_RESET  = 8'h00;
  localparam logic [FADDR_W-1:0] FADDR_RESET = 16'h0000;

  // Timing
  localparam int EW_TIME_SHORT_NS  = 2000;
  localparam int EW_TIME_LONG_NS   = 4000;
  localparam int UNLOCK_TIME_NS    = 4000;
  localparam int READ_INSTR_CYCLES = 3;
  localparam int CLOCKS_PER_INSTR  = 1;
  localparam int EW_SHORT_CYCLES   = ns_to_cycles(EW_TIME_SHORT_NS);
  localparam int EW_LONG_CYCLES    = ns_to_cycles(EW_TIME_LONG_NS);
  localparam int UNLOCK_CYCLES     = ns_to_cycles(UNLOCK_TIME_NS);
  localparam int READ_CYCLES       = READ_INSTR_CYCLES * CLOCKS_PER_INSTR;

  // Unlock pattern and the register that takes each byte
  localparam int UNLOCK_LEN = 6;
  localparam logic [7:0] UNLOCK_PATTERN [UNLOCK_LEN] =
    '{8'h00, 8'h0D, 8'hC3, 8'h04, 8'h09, 8'h40};
  localparam logic [7:0] UNLOCK_OFS [UNLOCK_LEN] =
    '{8'h18, 8'h20, 8'h28, 8'h1C, 8'h24, 8'h2C};
  localparam logic [2:0] STEP_DONE = 3'h6;
  localparam logic [2:0] STEP_FAIL = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_WAIT,
    ST_READ
  } ifs_state_type;

endpackage

// ---- rtl/ifs_write_buffer.sv ----
// Page write buffer with one load tag per word
`timescale 1ns/10ps
module ifs_write_buffer #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 16,
  parameter int IDX_W = 7
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clear,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  rd_tag
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] tag;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      tag <= '0;
    end else if (wr_en) begin
      tag[wr_idx] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (clear) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem[rd_idx];
  assign rd_tag  = tag[rd_idx];

endmodule // ifs_write_buffer

// ---- rtl/ifs_top.sv ----
// Flash erase, write and read sequencer with an AXI4-Lite register slave
`timescale 1ns/10ps
module ifs_top
  import ifs_pkg::*;
#(
  parameter int EW_SHORT = ifs_pkg::EW_SHORT_CYCLES,
  parameter int EW_LONG  = ifs_pkg::EW_LONG_CYCLES,
  parameter int UNLOCK_T = ifs_pkg::UNLOCK_CYCLES
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [ifs_pkg::REG_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [ifs_pkg::REG_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  output logic                                  cpu_stall,
  output logic [ifs_pkg::FADDR_W-1:0]           flash_addr,
  output logic [ifs_pkg::WORD_W-1:0]            flash_wdata,
  output logic                                  flash_erase,
  output logic                                  flash_prog,
  output logic                                  flash_read,
  input  wire logic [ifs_pkg::WORD_W-1:0]       flash_rdata
);

  import ifs_pkg::*;

  function automatic logic is_data(input logic [7:0] ofs);
    return (ofs >= OFS_DATA_BASE) && (ofs <= OFS_DATA_LAST) && (ofs[1:0] == 2'h0);
  endfunction

  function automatic logic is_mapped(input logic [7:0] ofs);
    return (ofs == OFS_CTRL) || (ofs == OFS_RCTRL) || (ofs == OFS_ADDR_LO) ||
           (ofs == OFS_ADDR_HI) || (ofs == OFS_STATUS) || is_data(ofs);
  endfunction

  ifs_state_type     state;
  logic [2:0]        command_mode_field;
  logic              write_erase_trigger;
  logic              unlock_trigger;
  logic              erase_write_enabled_flag;
  logic              read_enable_bit;
  logic              read_trigger;
  logic              write_erase_time_select;
  logic [FADDR_W-1:0] flash_address;
  logic [7:0]        data_low [NUM_DATA];
  logic [7:0]        data_high [NUM_DATA];
  logic [TIMER_W-1:0] op_timer;
  logic [TIMER_W-1:0] unlock_timer;
  logic [2:0]        unlock_step;
  logic [IDX_W-1:0]  prog_idx;
  logic [WORD_W-1:0] buf_data;
  logic              buf_tag;
  logic              busy;

  logic              aw_full;
  logic              w_full;
  logic              ar_full;
  logic [7:0]        awaddr_q;
  logic [7:0]        araddr_q;
  logic [7:0]        wbyte_q;
  logic              wstrb0_q;
  logic              next_aw_full;
  logic              next_w_full;
  logic              next_ar_full;
  logic              do_write;
  logic              do_read;
  logic              wr_byte_en;
  logic              ctrl_wr;
  logic              rctrl_wr;
  logic              hi0_wr;
  logic              data_wr;
  logic [1:0]        data_sel;
  logic              req_wt;
  logic              req_ut;
  logic              req_rd;
  logic              req_clear_write_buffer_bit;
  logic              clr_en;
  logic              set_en;
  logic              rd_load;
  logic [31:0]       rd_word;

  assign busy = (state != ST_IDLE);

  // Bus accesses wait while the processor is stalled
  always_comb begin
    do_write     = aw_full && w_full && !s_axi_bvalid && !busy;
    do_read      = ar_full && !s_axi_rvalid && !busy;
    next_aw_full = (aw_full && !do_write) || (s_axi_awvalid && s_axi_awready);
    next_w_full  = (w_full && !do_write) || (s_axi_wvalid && s_axi_wready);
    next_ar_full = (ar_full && !do_read) || (s_axi_arvalid && s_axi_arready);
  end

  // Write decode and command requests
  always_comb begin
    wr_byte_en = do_write && wstrb0_q;
    ctrl_wr    = wr_byte_en && (awaddr_q == OFS_CTRL);
    rctrl_wr   = wr_byte_en && (awaddr_q == OFS_RCTRL);
    hi0_wr     = wr_byte_en && (awaddr_q == OFS_DATA_HI0);
    data_wr    = wr_byte_en && is_data(awaddr_q);
    data_sel   = 2'((awaddr_q - OFS_DATA_BASE) >> 3);
    req_wt     = ctrl_wr && wbyte_q[CTRL_WT_BIT] && erase_write_enabled_flag &&
                 ((wbyte_q[2:0] == MODE_ERASE) || (wbyte_q[2:0] == MODE_WRITE));
    req_ut     = ctrl_wr && wbyte_q[CTRL_UT_BIT] && (wbyte_q[2:0] == MODE_UNLOCK);
    req_clear_write_buffer_bit   = ctrl_wr && wbyte_q[CTRL_CLEAR_WRITE_BUFFER_BIT_BIT];
    clr_en     = ctrl_wr && !wbyte_q[CTRL_EN_BIT];
    req_rd     = rctrl_wr && wbyte_q[RCTRL_RT_BIT] && read_enable_bit &&
                 (command_mode_field == MODE_READ);
    rd_load    = (state == ST_READ) && (op_timer == '0);
    set_en     = unlock_trigger && data_wr && (unlock_step < STEP_DONE) &&
                 (awaddr_q == UNLOCK_OFS[unlock_step]) &&
                 (wbyte_q == UNLOCK_PATTERN[unlock_step]) &&
                 (unlock_step == 3'(UNLOCK_LEN - 1));
  end

  // AXI write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_q      <= BYTE_RESET;
      wbyte_q       <= BYTE_RESET;
      wstrb0_q      <= 1'b0;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= !next_aw_full;
      s_axi_wready  <= !next_w_full;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wbyte_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (araddr_q == OFS_CTRL) begin
      rd_word[2:0]           = command_mode_field;
      rd_word[CTRL_WT_BIT]   = write_erase_trigger;
      rd_word[CTRL_UT_BIT]   = unlock_trigger;
      rd_word[CTRL_EN_BIT]   = erase_write_enabled_flag;
      rd_word[CTRL_RDEN_BIT] = read_enable_bit;
    end else if (araddr_q == OFS_RCTRL) begin
      rd_word[RCTRL_RT_BIT]   = read_trigger;
      rd_word[RCTRL_TSEL_BIT] = write_erase_time_select;
    end else if (araddr_q == OFS_ADDR_LO) begin
      rd_word[7:0] = flash_address[7:0];
    end else if (araddr_q == OFS_ADDR_HI) begin
      rd_word[7:0] = flash_address[15:8];
    end else if (araddr_q == OFS_STATUS) begin
      rd_word[STAT_BUSY_BIT]   = busy;
      rd_word[STAT_WINDOW_BIT] = unlock_trigger;
    end else if (is_data(araddr_q)) begin
      rd_word[7:0] = araddr_q[2] ? data_high[2'((araddr_q - OFS_DATA_BASE) >> 3)]
                                 : data_low[2'((araddr_q - OFS_DATA_BASE) >> 3)];
    end
  end

  // AXI read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_full       <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      araddr_q      <= BYTE_RESET;
    end else begin
      ar_full       <= next_ar_full;
      s_axi_arready <= !next_ar_full;
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_q <= s_axi_araddr;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= is_mapped(araddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software-held fields, address pair and data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      command_mode_field      <= MODE_WRITE;
      read_enable_bit         <= 1'b0;
      write_erase_time_select <= 1'b0;
      flash_address           <= FADDR_RESET;
      for (int i = 0; i < NUM_DATA; i++) begin
        data_low[i]  <= BYTE_RESET;
        data_high[i] <= BYTE_RESET;
      end
    end else begin
      if (ctrl_wr) begin
        command_mode_field <= wbyte_q[2:0];
        read_enable_bit    <= wbyte_q[CTRL_RDEN_BIT];
      end
      if (rctrl_wr) begin
        write_erase_time_select <= wbyte_q[RCTRL_TSEL_BIT];
      end
      if (wr_byte_en && (awaddr_q == OFS_ADDR_LO)) begin
        flash_address[7:0] <= wbyte_q;
      end
      if (wr_byte_en && (awaddr_q == OFS_ADDR_HI)) begin
        flash_address[15:8] <= wbyte_q;
      end
      if (data_wr) begin
        if (awaddr_q[2]) begin
          data_high[data_sel] <= wbyte_q;
        end else begin
          data_low[data_sel] <= wbyte_q;
        end
      end
      if (hi0_wr && (flash_address[IDX_W-1:0] != IDX_W'(PAGE_WORDS - 1))) begin
        flash_address <= flash_address + FADDR_W'(1);
      end
      if (rd_load) begin
        data_low[0]  <= flash_rdata[7:0];
        data_high[0] <= flash_rdata[15:8];
      end
    end
  end

  // Unlock window and enabled flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_trigger           <= 1'b0;
      unlock_timer             <= '0;
      unlock_step              <= 3'h0;
      erase_write_enabled_flag <= 1'b0;
    end else begin
      if (req_ut && !unlock_trigger) begin
        unlock_trigger <= 1'b1;
        unlock_timer   <= TIMER_W'(UNLOCK_T - 1);
        unlock_step    <= 3'h0;
      end else if (unlock_trigger) begin
        if (unlock_timer == '0) begin
          unlock_trigger <= 1'b0;
        end else begin
          unlock_timer <= unlock_timer - TIMER_W'(1);
        end
        if (data_wr && (unlock_step < STEP_DONE)) begin
          if ((awaddr_q == UNLOCK_OFS[unlock_step]) &&
              (wbyte_q == UNLOCK_PATTERN[unlock_step])) begin
            unlock_step <= unlock_step + 3'h1;
          end else begin
            unlock_step <= STEP_FAIL;
          end
        end
      end
      if (clr_en) begin
        erase_write_enabled_flag <= 1'b0;
      end
      if (set_en) begin
        erase_write_enabled_flag <= 1'b1;
      end
    end
  end

  // Erase, program and read sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state               <= ST_IDLE;
      write_erase_trigger <= 1'b0;
      read_trigger        <= 1'b0;
      op_timer            <= '0;
      prog_idx            <= '0;
      cpu_stall           <= 1'b0;
      flash_addr          <= FADDR_RESET;
      flash_wdata         <= '0;
      flash_erase         <= 1'b0;
      flash_prog          <= 1'b0;
      flash_read          <= 1'b0;
    end else begin
      flash_erase <= 1'b0;
      flash_prog  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_wt) begin
            write_erase_trigger <= 1'b1;
            cpu_stall           <= 1'b1;
            prog_idx            <= '0;
            if (wbyte_q[2:0] == MODE_ERASE) begin
              flash_erase <= 1'b1;
              flash_addr  <= {flash_address[FADDR_W-1:IDX_W], IDX_W'(0)};
              op_timer    <= write_erase_time_select ? TIMER_W'(EW_LONG - 1)
                                                     : TIMER_W'(EW_SHORT - 1);
              state       <= ST_WAIT;
            end else begin
              state <= ST_PROG;
            end
          end else if (req_rd) begin
            read_trigger <= 1'b1;
            cpu_stall    <= 1'b1;
            flash_read   <= 1'b1;
            flash_addr   <= flash_address;
            op_timer     <= TIMER_W'(READ_CYCLES - 1);
            state        <= ST_READ;
          end
        end
        ST_PROG: begin
          if (buf_tag) begin
            flash_prog  <= 1'b1;
            flash_addr  <= {flash_address[FADDR_W-1:IDX_W], prog_idx};
            flash_wdata <= buf_data;
          end
          if (prog_idx == IDX_W'(PAGE_WORDS - 1)) begin
            op_timer <= write_erase_time_select ? TIMER_W'(EW_LONG - 1)
                                                : TIMER_W'(EW_SHORT - 1);
            state    <= ST_WAIT;
          end else begin
            prog_idx <= prog_idx + IDX_W'(1);
          end
        end
        ST_WAIT: begin
          if (op_timer == '0) begin
            write_erase_trigger <= 1'b0;
            cpu_stall           <= 1'b0;
            state               <= ST_IDLE;
          end else begin
            op_timer <= op_timer - TIMER_W'(1);
          end
        end
        ST_READ: begin
          if (op_timer == '0) begin
            read_trigger <= 1'b0;
            cpu_stall    <= 1'b0;
            flash_read   <= 1'b0;
            state        <= ST_IDLE;
          end else begin
            op_timer <= op_timer - TIMER_W'(1);
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ifs_write_buffer #(
    .DEPTH (PAGE_WORDS),
    .WIDTH (WORD_W),
    .IDX_W (IDX_W)
  ) u_buffer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (req_clear_write_buffer_bit),
    .wr_en   (hi0_wr),
    .wr_idx  (flash_address[IDX_W-1:0]),
    .wr_data ({wbyte_q, data_low[0]}),
    .rd_idx  (prog_idx),
    .rd_data (buf_data),
    .rd_tag  (buf_tag)
  );

endmodule // ifs_top

// ---- bench/ifs_props.sv ----
// Port-level checks for the flash sequencer
`timescale 1ns/10ps
module ifs_props #(
  parameter int EW_SHORT = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        cpu_stall,
  input wire logic [15:0] flash_addr,
  input wire logic        flash_erase,
  input wire logic        flash_prog,
  input wire logic        flash_read
);
  logic [15:0] scnt;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Length of the current stall
  always_ff @(posedge aclk) begin
    if (!aresetn) scnt <= 16'h0000;
    else if (cpu_stall) scnt <= scnt + 16'h0001;
    else scnt <= 16'h0000;
  end

  property p_erase_stall; flash_erase |-> cpu_stall; endproperty
  a_erase_stall: assert property (p_erase_stall) else $error("erase without stall");
  property p_prog_stall; flash_prog |-> cpu_stall; endproperty
  a_prog_stall: assert property (p_prog_stall) else $error("program without stall");
  property p_read_stall; flash_read |-> cpu_stall; endproperty
  a_read_stall: assert property (p_read_stall) else $error("read without stall");
  property p_read_len; $rose(flash_read) |-> flash_read[*3] ##1 !flash_read; endproperty
  a_read_len: assert property (p_read_len) else $error("read length wrong");
  property p_erase_page; flash_erase |-> flash_addr[6:0] == 7'h00 ##1 !flash_erase; endproperty
  a_erase_page: assert property (p_erase_page) else $error("erase not page wide");
  property p_stall_len; $fell(cpu_stall) |-> (scnt == 16'h0003 || scnt >= EW_SHORT); endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_stall_end; $rose(cpu_stall) |-> ##[1:300] !cpu_stall; endproperty
  a_stall_end: assert property (p_stall_end) else $error("stall never ends");
  property p_quiet; !cpu_stall |-> !flash_prog && !flash_read; endproperty
  a_quiet: assert property (p_quiet) else $error("flash strobe while idle");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");

  c_erase: cover property (flash_erase);
  c_prog: cover property (flash_prog);
  c_read: cover property ($fell(flash_read));
endmodule // ifs_props

// ---- bench/ifs_tb.sv ----
// Self-checking bench for the flash sequencer
`timescale 1ns/10ps
module ifs_tb;
  import ifs_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [15:0] flash_rdata, rdv, ra, w, a;
  logic [15:0] ew [3];
  logic [1:0]  r;
  logic [8:0]  pg;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         cpu_stall, flash_erase, flash_prog, flash_read;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] flash_addr, flash_wdata;
  int          num_errors, n_tests, n_erase, n_rd, scnt, last_stall, s;
  logic [31:0] prog_q [$];

  ifs_top #(.EW_SHORT(4), .EW_LONG(8), .UNLOCK_T(50)) i_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_stall, .flash_addr, .flash_wdata,
    .flash_erase, .flash_prog, .flash_read, .flash_rdata);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Flash returns rdv while read runs and random data otherwise
  always @(posedge aclk) begin
    flash_rdata <= flash_read ? rdv : 16'($urandom);
    if (flash_erase) n_erase++;
    if (flash_read) n_rd++;
    if (flash_read) ra = flash_addr;
    if (flash_prog) prog_q.push_back({flash_addr, flash_wdata});
    if (cpu_stall) scnt++;
    else if (scnt != 0) begin
      last_stall = scnt;
      scnt = 0;
    end
  end

  function automatic int slot(input int k);
    return (k > 2) ? 2 : k;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h000000, dt};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic sa(input logic [15:0] x);
    wr(8'h08, x[7:0]);
    wr(8'h0C, x[15:8]);
  endtask

  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rdv} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'h1E3E));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00);
    chk(d, 32'h00000000);
    rd(8'h40);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h44, 8'h5A);
    chk(r, RESP_SLVERR);
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h01);
    rd(8'h04);
    chk(n_rd, 0);
    for (int i = 0; i < 3; i++) begin
      rdv = 16'($urandom);
      a = 16'($urandom);
      sa(a);
      wr(8'h00, 8'h83);
      wr(8'h04, 8'h01);
      rd(8'h10);
      w = d[15:0];
      rd(8'h14);
      chk({d[7:0], w[7:0]}, rdv);
      chk(ra, a);
      chk(last_stall, 3);
    end
    wr(8'h00, 8'h09);
    rd(8'h00);
    chk(n_erase, 0);
    wr(8'h00, 8'h16);
    wr(8'h18, 8'h01);
    repeat (60) @(posedge aclk);
    rd(8'h00);
    chk(d[6:4], 3'h0);
    wr(8'h00, 8'h16);
    for (int k = 0; k < 6; k++) wr(UNLOCK_OFS[k], UNLOCK_PATTERN[k]);
    rd(8'h00);
    chk(d[6], 1'b1);
    rd(8'h30);
    chk(d[1:0], 2'h2);
    pg = 9'($urandom);
    sa({pg, 7'h05});
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h69);
    rd(8'h00);
    chk(d[3], 1'b0);
    chk(n_erase, 1);
    s = last_stall;
    wr(8'h04, 8'h02);
    wr(8'h00, 8'h69);
    rd(8'h00);
    chk(last_stall > s, 1'b1);
    sa({pg, 7'h7D});
    for (int k = 0; k < 5; k++) begin
      w = 16'($urandom);
      wr(8'h10, w[7:0]);
      wr(8'h14, w[15:8]);
      ew[slot(k)] = w;
    end
    wr(8'h10, 8'hEE);
    prog_q.delete();
    wr(8'h00, 8'h48);
    rd(8'h08);
    chk(d[7:0], {pg[0], 7'h7F});
    chk(prog_q.size(), 3);
    for (int k = 0; k < 3; k++) chk(prog_q[k], {pg, 7'(125 + k), ew[k]});
    wr(8'h00, 8'h60);
    prog_q.delete();
    wr(8'h00, 8'h48);
    rd(8'h00);
    chk(prog_q.size(), 0);
    wr(8'h14, 8'h3C);
    wr(8'h00, 8'h48);
    rd(8'h00);
    chk(prog_q.size(), 1);
    chk(prog_q[0], {pg, 7'h7F, 16'h3CEE});
    wr(8'h00, 8'h00);
    rd(8'h00);
    chk(d[6], 1'b0);
    wr(8'h00, 8'h09);
    rd(8'h00);
    chk(n_erase, 2);
    wrap_up();
  end
endmodule // ifs_tb

bind ifs_top ifs_props #(.EW_SHORT(EW_SHORT)) i_props (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_stall,
  .flash_addr, .flash_erase, .flash_prog, .flash_read);
